// >>> hw/cf_card_end.sv
// Card end of the flash card host port: personality, decode, lanes, status pins and data FIFO.
`include "cf_regs.svh"
`default_nettype none
module cf_card_end
  import cf_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  cf_bus_if.card           bus,
  output logic [15:0]      outWord,
  output logic             outValid,
  input  wire logic        outReady,
  input  wire logic [15:0] readWord,
  input  wire logic        wpLevel,
  input  wire logic        dmaEnable,
  input  wire logic        diagPass,
  input  wire logic        diskActive,
  output cf_mode_t         modeNow,
  output logic             peerDiag,
  output logic             peerActive
);
  cf_mode_t    mode_q;
  logic        armed_q;
  logic [7:0]  taskReg_q [8];
  logic [7:0]  option_q;
  logic [7:0]  cfgSts_q;
  logic        rdPrev_q;
  logic        wrPrev_q;
  logic        readyPrev_q;
  logic        wpPrev_q;
  logic [15:0] cData_q;
  logic        oeLo_q;
  logic        oeHi_q;
  logic        rdNow;
  logic        wrNow;
  logic        attrAcc;
  logic        laneLo;
  logic        laneHi;
  logic [2:0]  idx;
  logic        inReady;
  logic        push;
  logic [7:0]  tfRead;
  logic [7:0]  attrRead;
  logic [15:0] pushWord;

  // Access decode per personality; cable select never enters it in any personality.
  always_comb begin
    rdNow   = 1'b0;
    wrNow   = 1'b0;
    attrAcc = 1'b0;
    laneLo  = 1'b0;
    laneHi  = 1'b0;
    idx     = bus.addr[2:0];
    unique case (mode_q)
      CF_IDE: begin
        // High address lines are don't-care here; only three bits choose the register.
        idx    = bus.addr[2:0];
        rdNow  = (!bus.ce1N || (dmaEnable && !bus.regN)) && !bus.iordN;
        wrNow  = (!bus.ce1N || (dmaEnable && !bus.regN)) && !bus.iowrN;
        if (dmaEnable && !bus.regN) begin
          idx = `CF_TF_DATA;
        end
        laneLo = 1'b1;
        laneHi = (idx == `CF_TF_DATA);
      end
      default: begin
        // Enables and A0 pick even byte, odd byte or word.
        laneLo = !bus.ce1N;
        laneHi = !bus.ce2N;
        if (!bus.ce1N && bus.ce2N) begin
          idx = bus.addr[2:0];
        end else begin
          idx = {bus.addr[2:1], !bus.ce2N && bus.ce1N};
        end
        attrAcc = !bus.regN && (mode_q == CF_MEM || bus.iordN && bus.iowrN);
        if (mode_q == CF_IO && !bus.regN && !(bus.iordN && bus.iowrN)) begin
          rdNow = (laneLo || laneHi) && !bus.iordN;
          wrNow = (laneLo || laneHi) && !bus.iowrN;
        end else begin
          rdNow = (laneLo || laneHi) && !bus.ataSelN;
          wrNow = (laneLo || laneHi) && !bus.weN;
        end
      end
    endcase
  end

  // Attribute space: option and status registers, the rest reads as structure bytes.
  always_comb begin
    unique case (bus.addr[9:0])
      `CF_ATTR_OPTION: attrRead = option_q;
      `CF_ATTR_STATUS: attrRead = cfgSts_q;
      default:         attrRead = `CF_CIS_FILL;
    endcase
    if (idx == `CF_TF_STATUS) begin
      tfRead = {1'b0, 1'b1, 2'b00, inReady, 3'b000};
    end else begin
      tfRead = taskReg_q[idx];
    end
  end

  // Personality is caught once reset lets go, from the ATA select level.
  always_ff @(posedge clk) begin
    if (srst || bus.cardReset) begin
      armed_q <= 1'b1;
      mode_q  <= CF_MEM;
    end else begin
      armed_q <= 1'b0;
      if (armed_q) begin
        mode_q <= bus.ataSelN ? CF_MEM : CF_IDE;
      end else if (mode_q == CF_MEM && wrNow && !wrPrev_q && attrAcc && bus.addr[9:0] == `CF_ATTR_OPTION
                   && bus.hData[5:0] != 6'h00) begin
        mode_q <= CF_IO;
      end
    end
  end

  // Strobe history makes each host write act once, on its leading edge.
  always_ff @(posedge clk) begin
    if (srst) begin
      rdPrev_q <= 1'b0;
      wrPrev_q <= 1'b0;
    end else begin
      rdPrev_q <= rdNow;
      wrPrev_q <= wrNow;
    end
  end

  // Task file byte writes land on the low lane only in IDE.
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < 8; i++) begin
        taskReg_q[i] <= 8'h00;
      end
    end else if (wrNow && !wrPrev_q && !attrAcc && idx != `CF_TF_DATA) begin
      if (laneLo) begin
        taskReg_q[idx] <= bus.hData[7:0];
      end else begin
        taskReg_q[idx] <= bus.hData[15:8];
      end
    end
  end

  // Configuration registers; a changed flag raised in the clearing cycle survives.
  always_ff @(posedge clk) begin
    if (srst || bus.cardReset) begin
      option_q    <= `CF_OPT_RESET;
      cfgSts_q    <= `CF_STS_RESET;
      readyPrev_q <= 1'b1;
      wpPrev_q    <= 1'b0;
    end else begin
      readyPrev_q <= inReady;
      wpPrev_q    <= wpLevel;
      if (wrNow && !wrPrev_q && attrAcc) begin
        if (bus.addr[9:0] == `CF_ATTR_OPTION) begin
          option_q <= bus.hData[7:0];
        end
        if (bus.addr[9:0] == `CF_ATTR_STATUS) begin
          cfgSts_q[`CF_STS_SIGEN] <= bus.hData[`CF_STS_SIGEN];
          if (bus.hData[`CF_STS_CHANGED]) begin
            cfgSts_q[`CF_STS_CHANGED] <= 1'b0;
          end
        end
      end
      if (inReady != readyPrev_q || wpLevel != wpPrev_q) begin
        cfgSts_q[`CF_STS_CHANGED] <= 1'b1;
      end
    end
  end

  // Data register writes feed the FIFO; a byte write fills the low half only.
  assign pushWord = laneHi && laneLo ? bus.hData : (laneLo ? {8'h00, bus.hData[7:0]} : {8'h00, bus.hData[15:8]});
  assign push     = wrNow && !wrPrev_q && !attrAcc && idx == `CF_TF_DATA;

  cf_fifo #(
    .WIDTH (`CF_FIFO_WIDTH),
    .DEPTH (`CF_FIFO_DEPTH)
  ) u_fifo (
    .clk      (clk),
    .srst     (srst),
    .inData   (pushWord),
    .inValid  (push),
    .inReady  (inReady),
    .outData  (outWord),
    .outValid (outValid),
    .outReady (outReady)
  );

  // Read data is registered, so it trails the strobe by one cycle.
  // Upper lane drives only for word or odd accesses, or IDE data register reads, so eight-bit hosts need none of it.
  always_ff @(posedge clk) begin
    if (srst) begin
      cData_q <= 16'h0000;
      oeLo_q  <= 1'b0;
      oeHi_q  <= 1'b0;
    end else begin
      oeLo_q <= rdNow && laneLo;
      oeHi_q <= rdNow && laneHi;
      if (attrAcc) begin
        cData_q <= {8'h00, attrRead};
      end else if (idx == `CF_TF_DATA && laneLo) begin
        cData_q <= laneHi ? readWord : {8'h00, readWord[7:0]};
      end else if (laneLo) begin
        cData_q <= {8'h00, tfRead};
      end else begin
        cData_q <= {tfRead, 8'h00};
      end
    end
  end

  // Status pins per personality; in IDE the two pins are open-drain handshake lines.
  always_ff @(posedge clk) begin
    if (srst) begin
      bus.bvd1Out  <= 1'b1;
      bus.bvd1Oe   <= 1'b0;
      bus.bvd2Out  <= 1'b1;
      bus.bvd2Oe   <= 1'b0;
      bus.readyOut <= 1'b0;
      bus.waitN    <= 1'b1;
      bus.inpackN  <= 1'b1;
      bus.wpOut    <= 1'b0;
      peerDiag     <= 1'b0;
      peerActive   <= 1'b0;
      modeNow      <= CF_MEM;
    end else begin
      modeNow     <= mode_q;
      bus.waitN   <= inReady;
      bus.inpackN <= !(mode_q == CF_IO && rdNow && !bus.iordN);
      unique case (mode_q)
        CF_MEM: begin
          bus.bvd1Out  <= 1'b1;
          bus.bvd1Oe   <= 1'b1;
          bus.bvd2Out  <= 1'b1;
          bus.bvd2Oe   <= 1'b1;
          bus.readyOut <= inReady;
          bus.wpOut    <= wpLevel;
        end
        CF_IO: begin
          bus.bvd1Out  <= !(cfgSts_q[`CF_STS_SIGEN] && cfgSts_q[`CF_STS_CHANGED]);
          bus.bvd1Oe   <= 1'b1;
          bus.bvd2Out  <= 1'b1;
          bus.bvd2Oe   <= 1'b1;
          bus.readyOut <= 1'b1;
          bus.wpOut    <= 1'b0;
        end
        default: begin
          bus.bvd1Out  <= 1'b0;
          bus.bvd1Oe   <= diagPass;
          bus.bvd2Out  <= 1'b0;
          bus.bvd2Oe   <= diskActive;
          bus.readyOut <= 1'b0;
          bus.wpOut    <= 1'b1;
        end
      endcase
      peerDiag   <= (mode_q == CF_IDE) && !bus.bvd1In;
      peerActive <= (mode_q == CF_IDE) && !bus.bvd2In;
    end
  end

  assign bus.cData     = cData_q;
  assign bus.cDataOeLo = oeLo_q;
  assign bus.cDataOeHi = oeHi_q;
endmodule
`default_nettype wire

// >>> hw/cf_regs.svh
// Constants for the flash card host port: offsets, fields, reset values and timing.
`ifndef CF_REGS_SVH
`define CF_REGS_SVH
`define CF_CLK_NS        5
`define CF_STROBE_NS     30
`define CF_STROBE_CYC    ((`CF_STROBE_NS + `CF_CLK_NS - 1) / `CF_CLK_NS)
`define CF_ATTR_OPTION   10'h200
`define CF_ATTR_STATUS   10'h202
`define CF_CIS_FILL      8'hff
`define CF_OPT_RESET     8'h00
`define CF_STS_RESET     8'h00
`define CF_STS_SIGEN     4
`define CF_STS_CHANGED   5
`define CF_TF_DATA       3'h0
`define CF_TF_STATUS     3'h7
`define CF_TF_RDY_BIT    6
`define CF_TF_DRQ_BIT    3
`define CF_FIFO_WIDTH    16
`define CF_FIFO_DEPTH    8
`endif

// >>> hw/cf_pkg.sv
// Types shared by both ends of the flash card host port.
`default_nettype none
package cf_pkg;
  typedef enum logic [1:0] {CF_MEM, CF_IO, CF_IDE} cf_mode_t;
  typedef enum logic [1:0] {CF_SP_ATTR, CF_SP_MEM, CF_SP_IO, CF_SP_IDE} cf_space_t;
  typedef enum logic [1:0] {CF_LANE_LO, CF_LANE_HI, CF_LANE_WORD} cf_lane_t;
endpackage
`default_nettype wire

// >>> hw/cf_bus_if.sv
// Pin bundle between the host controller and the card, one modport per end.
`default_nettype none
interface cf_bus_if;
  logic [10:0] addr;
  logic [15:0] hData;
  logic        hDataOe;
  logic        ce1N;
  logic        ce2N;
  logic        ataSelN;
  logic        weN;
  logic        iordN;
  logic        iowrN;
  logic        regN;
  logic        cselN;
  logic        cardReset;
  logic [15:0] cData;
  logic        cDataOeLo;
  logic        cDataOeHi;
  logic        readyOut;
  logic        waitN;
  logic        inpackN;
  logic        wpOut;
  logic        bvd1Out;
  logic        bvd1Oe;
  logic        bvd2Out;
  logic        bvd2Oe;
  logic        bvd1In;
  logic        bvd2In;
  modport card (input addr, hData, hDataOe, ce1N, ce2N, ataSelN, weN, iordN, iowrN, regN, cselN, cardReset,
                bvd1In, bvd2In,
                output cData, cDataOeLo, cDataOeHi, readyOut, waitN, inpackN, wpOut, bvd1Out, bvd1Oe,
                bvd2Out, bvd2Oe);
  modport host (output addr, hData, hDataOe, ce1N, ce2N, ataSelN, weN, iordN, iowrN, regN, cselN, cardReset,
                input cData, cDataOeLo, cDataOeHi, readyOut, waitN, inpackN, wpOut, bvd1In, bvd2In);
endinterface
`default_nettype wire

// >>> hw/cf_fifo.sv
// Synchronous FIFO with valid and ready on both sides.
`default_nettype none
module cf_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_q;
  logic [AW-1:0]    rdPtr_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;

  // Full and empty come straight from the occupancy count.
  assign inReady  = (count_q != (AW+1)'(DEPTH));
  assign outValid = (count_q != '0);
  assign outData  = mem[rdPtr_q];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  // Storage is written only on an accepted push.
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end

  // Pointers wrap at the depth, which need not be a power of two.
  always_ff @(posedge clk) begin
    if (srst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wrPtr_q <= (wrPtr_q == AW'(DEPTH-1)) ? '0 : wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= (rdPtr_q == AW'(DEPTH-1)) ? '0 : rdPtr_q + 1'b1;
      end
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// >>> hw/cf_host_end.sv
// Host end of the flash card host port: turns user commands into strobed pin cycles.
`include "cf_regs.svh"
`default_nettype none
module cf_host_end
  import cf_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  cf_bus_if.host           bus,
  input  wire logic        ideMode,
  input  wire logic        hostReset,
  input  wire logic        a25,
  input  wire logic        cmdValid,
  output logic             cmdReady,
  input  wire logic        cmdWrite,
  input  wire cf_space_t   cmdSpace,
  input  wire cf_lane_t    cmdLane,
  input  wire logic [10:0] cmdAddr,
  input  wire logic [15:0] cmdData,
  output logic             rspValid,
  output logic [15:0]      rspData
);
  typedef enum logic [1:0] {CF_H_IDLE, CF_H_SETUP, CF_H_STROBE, CF_H_HOLD} cf_hstate_t;
  localparam logic [3:0] STROBE_LAST = 4'(`CF_STROBE_CYC - 1);
  cf_hstate_t  state_q;
  logic [3:0]  cnt_q;
  logic        write_q;
  cf_space_t   space_q;
  cf_lane_t    lane_q;

  // Cycle sequencer: setup waits out card back-pressure before a write strobe.
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q  <= CF_H_IDLE;
      cnt_q    <= 4'h0;
      cmdReady <= 1'b0;
      rspValid <= 1'b0;
      rspData  <= 16'h0000;
      write_q  <= 1'b0;
      space_q  <= CF_SP_MEM;
      lane_q   <= CF_LANE_LO;
    end else begin
      rspValid <= 1'b0;
      cmdReady <= 1'b0;
      unique case (state_q)
        CF_H_IDLE: begin
          cmdReady <= 1'b1;
          if (cmdValid && cmdReady) begin
            cmdReady <= 1'b0;
            write_q  <= cmdWrite;
            space_q  <= ideMode ? CF_SP_IDE : cmdSpace;
            // Task file registers go over the low lane only in IDE.
            lane_q   <= (ideMode && cmdAddr[2:0] != `CF_TF_DATA) ? CF_LANE_LO : cmdLane;
            state_q  <= CF_H_SETUP;
          end
        end
        CF_H_SETUP: begin
          cnt_q <= 4'h0;
          if (!write_q || bus.waitN) begin
            state_q <= CF_H_STROBE;
          end
        end
        CF_H_STROBE: begin
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == STROBE_LAST) begin
            rspData <= bus.cData;
            state_q <= CF_H_HOLD;
          end
        end
        CF_H_HOLD: begin
          rspValid <= !write_q;
          state_q  <= CF_H_IDLE;
        end
      endcase
    end
  end

  // Pin drive; unused inputs are held at their required levels in every state.
  always_ff @(posedge clk) begin
    if (srst) begin
      bus.addr      <= 11'h000;
      bus.hData     <= 16'h0000;
      bus.hDataOe   <= 1'b0;
      bus.ce1N      <= 1'b1;
      bus.ce2N      <= 1'b1;
      bus.ataSelN   <= 1'b1;
      bus.weN       <= 1'b1;
      bus.iordN     <= 1'b1;
      bus.iowrN     <= 1'b1;
      bus.regN      <= 1'b1;
      bus.cselN     <= 1'b0;
      bus.cardReset <= 1'b1;
    end else begin
      bus.cardReset <= hostReset;
      bus.cselN     <= ideMode ? 1'b0 : a25;
      bus.regN      <= ideMode ? 1'b1
                       : !(state_q != CF_H_IDLE && (space_q == CF_SP_ATTR || space_q == CF_SP_IO));
      if (state_q == CF_H_IDLE && cmdValid && cmdReady) begin
        // Higher address lines are grounded in IDE.
        bus.addr    <= ideMode ? {8'h00, cmdAddr[2:0]} : cmdAddr;
        // Even byte on D00 upward, odd byte on D08 upward.
        bus.hData   <= (cmdLane == CF_LANE_HI) ? {cmdData[7:0], 8'h00} : cmdData;
        bus.hDataOe <= cmdWrite;
      end else if (state_q == CF_H_HOLD) begin
        bus.hDataOe <= 1'b0;
      end
      bus.ce1N <= !(state_q != CF_H_IDLE && state_q != CF_H_HOLD && lane_q != CF_LANE_HI);
      bus.ce2N <= !(state_q != CF_H_IDLE && state_q != CF_H_HOLD && lane_q != CF_LANE_LO);
      bus.ataSelN <= ideMode ? 1'b0 : !(state_q == CF_H_STROBE && !write_q && space_q != CF_SP_IO);
      bus.weN     <= ideMode ? 1'b1 : !(state_q == CF_H_STROBE && write_q && space_q != CF_SP_IO);
      bus.iordN   <= !(state_q == CF_H_STROBE && !write_q && (space_q == CF_SP_IO || space_q == CF_SP_IDE));
      bus.iowrN   <= !(state_q == CF_H_STROBE && write_q && (space_q == CF_SP_IO || space_q == CF_SP_IDE));
    end
  end
endmodule
`default_nettype wire

// >>> verif/cf_port_asserts.sv
// Concurrent checks on the pins between the host end and the card end.
`default_nettype none
module cf_port_asserts (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic [10:0] addr,
  input wire logic        ce1N,
  input wire logic        ce2N,
  input wire logic        ataSelN,
  input wire logic        weN,
  input wire logic        iordN,
  input wire logic        iowrN,
  input wire logic        regN,
  input wire logic        cardReset,
  input wire logic        cDataOeLo,
  input wire logic        cDataOeHi,
  input wire logic        bvd1Out,
  input wire logic        bvd2Out,
  input wire logic        bvd2Oe
);
  logic       armed_q;
  logic       ide_q;
  logic [1:0] settle_q;
  wire logic  ok = !armed_q && settle_q == 2'h3;

  // Mirror of the personality capture; checks wait until the card's outputs have settled after it.
  always_ff @(posedge clk) begin
    if (srst || cardReset) begin
      armed_q <= 1'b1;
      settle_q <= 2'h0;
    end else if (armed_q) begin
      armed_q <= 1'b0;
      ide_q <= !ataSelN;
    end else if (settle_q != 2'h3) begin
      settle_q <= settle_q + 2'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  ide_we_tied_a: assert property (ok && ide_q |-> weN) else $error("write strobe moved in IDE mode");
  ide_sel_low_a: assert property (ok && ide_q |-> !ataSelN) else $error("select pin high in IDE mode");
  ide_dmack_a: assert property (ok && ide_q |-> regN) else $error("DMA acknowledge low without DMA");
  ide_addr_a: assert property (ok && ide_q && !(iordN && iowrN) |-> addr[10:3] == 8'h00)
    else $error("upper address lines not grounded");
  pc_status_a: assert property (ok && !ide_q |-> bvd2Oe && bvd2Out) else $error("status pin two not high");
  ide_drain_a: assert property (ok && ide_q |-> !bvd1Out && !bvd2Out) else $error("open drain drives high");
  ide_task_lane_a: assert property (ok && ide_q && !ce1N && ce2N && $fell(iordN) |=> cDataOeLo && !cDataOeHi)
    else $error("task register read not on low lane");
  word_lanes_a: assert property (ok && !ce1N && !ce2N && $fell(iordN) |=> cDataOeLo && cDataOeHi)
    else $error("word read not on both lanes");
  odd_lane_a: assert property (ok && !ide_q && ce1N && !ce2N && $fell(iordN) |=> !cDataOeLo && cDataOeHi)
    else $error("odd byte read not on upper lane");

  cover property (ok && ide_q && $fell(iordN));
  cover property (ok && !ide_q && $fell(weN));
  cover property (ok && !ide_q && ce1N && !ce2N && $fell(iordN));
endmodule
`default_nettype wire

// >>> verif/testbench.sv
// Self-checking bench joining the host end and the card end of the flash card port.
`default_nettype none
module testbench
  import cf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, srst = 1'b1, ideMode = 1'b0, hostReset = 1'b0, a25 = 1'b0;
  logic        cmdValid = 1'b0, cmdWrite = 1'b0, outReady = 1'b0, wpLevel = 1'b0;
  logic        dmaEnable = 1'b0, diagPass = 1'b0, diskActive = 1'b0, en = 1'b0, chg = 1'b0;
  logic        cmdReady, rspValid, outValid, peerDiag, peerActive;
  cf_space_t   cmdSpace = CF_SP_ATTR;
  cf_lane_t    cmdLane = CF_LANE_LO;
  cf_mode_t    modeNow;
  logic [10:0] cmdAddr = 11'h000;
  logic [15:0] cmdData = 16'h0000, readWord = 16'h0000, rspData, outWord, rd, d;
  logic [15:0] q[$];
  logic [7:0]  wv[5] = '{8'h30, 8'h10, 8'h30, 8'h20, 8'h20};
  logic        fl[5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  int          badCount = 0, nTests = 0, seed = 57;
  cf_bus_if bus();

  // Status pins carry pull-ups; an enabled driver wins, which also models the open-drain IDE use.
  assign bus.bvd1In = bus.bvd1Oe ? bus.bvd1Out : 1'b1;
  assign bus.bvd2In = bus.bvd2Oe ? bus.bvd2Out : 1'b1;

  always #2.5 clk = ~clk;

  cf_host_end cf_host_end_inst (.clk(clk), .srst(srst), .bus(bus), .ideMode(ideMode), .hostReset(hostReset),
    .a25(a25), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdWrite(cmdWrite), .cmdSpace(cmdSpace),
    .cmdLane(cmdLane), .cmdAddr(cmdAddr), .cmdData(cmdData), .rspValid(rspValid), .rspData(rspData));
  cf_card_end cf_card_end_inst (.clk(clk), .srst(srst), .bus(bus), .outWord(outWord), .outValid(outValid),
    .outReady(outReady), .readWord(readWord), .wpLevel(wpLevel), .dmaEnable(dmaEnable), .diagPass(diagPass),
    .diskActive(diskActive), .modeNow(modeNow), .peerDiag(peerDiag), .peerActive(peerActive));
  cf_port_asserts cf_port_asserts_inst (.clk(clk), .srst(srst), .addr(bus.addr), .ce1N(bus.ce1N),
    .ce2N(bus.ce2N), .ataSelN(bus.ataSelN), .weN(bus.weN), .iordN(bus.iordN), .iowrN(bus.iowrN),
    .regN(bus.regN), .cardReset(bus.cardReset), .cDataOeLo(bus.cDataOeLo), .cDataOeHi(bus.cDataOeHi),
    .bvd1Out(bus.bvd1Out), .bvd2Out(bus.bvd2Out), .bvd2Oe(bus.bvd2Oe));

  // One comparison; four-state equality so an unknown matches only an unknown in the same bit.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    nTests++;
    if (seen !== exp) begin
      badCount++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  // One host command; writes then wait out the whole pin cycle, reads return the response word.
  task automatic hcmd(input logic w, input cf_space_t s, input cf_lane_t l, input logic [10:0] a,
                      input logic [15:0] dat, output logic [15:0] r);
    a25 = 1'($random(seed));
    cmdWrite = w;
    cmdSpace = s;
    cmdLane  = l;
    cmdAddr  = a;
    cmdData  = dat;
    cmdValid = 1'b1;
    while (cmdReady !== 1'b1) @(negedge clk);
    @(negedge clk);
    cmdValid = 1'b0;
    r = 16'hxxxx;
    if (w) tick(12);
    else begin
      do @(negedge clk); while (rspValid !== 1'b1);
      r = rspData;
    end
  endtask

  // Data register writes; byte writes land zero-extended in the card FIFO.
  task automatic fill(input cf_space_t s, input int n, input logic bytes);
    for (int i = 0; i < n; i++) begin
      d = 16'($random(seed));
      hcmd(1'b1, s, (bytes && !i[0]) ? CF_LANE_LO : CF_LANE_WORD, 11'h000, d, rd);
      q.push_back((bytes && !i[0]) ? {8'h00, d[7:0]} : d);
    end
  endtask

  // Pops the FIFO against the model; the consumer stalls a cycle between pops.
  task automatic drain();
    while (q.size() > 0) begin
      check(outValid, 1'b1, "fifo holds word");
      check(outWord, q.pop_front(), "fifo word");
      outReady = 1'b1;
      @(negedge clk);
      outReady = 1'b0;
      @(negedge clk);
    end
    check(outValid, 1'b0, "fifo empty");
  endtask

  // Writes the status register, optionally flips write protect, and checks register and alert pin.
  task automatic alert(input logic [7:0] w, input logic flip, input logic [7:0] exp);
    hcmd(1'b1, CF_SP_ATTR, CF_LANE_LO, 11'h202, {8'h00, w}, rd);
    wpLevel = wpLevel ^ flip;
    tick(4);
    hcmd(1'b0, CF_SP_ATTR, CF_LANE_LO, 11'h202, 16'h0000, rd);
    check(rd[7:0], exp, "status register");
    check(bus.bvd1In, !(exp[4] && exp[5]), "change alert");
  endtask

  task automatic testDone();
    $display("comparisons %0d mismatches %0d", nTests, badCount);
    if (badCount == 0 && nTests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Watchdog: the whole sequence needs well under two thousand cycles.
  initial begin
    #(20000 * 5);
    badCount++;
    $display("mismatch at %0t: watchdog expired", $time);
    testDone();
  end

  initial begin
    tick(10);
    srst = 1'b0;
    tick(4);
    check(modeNow, CF_MEM, "mode after reset");
    check(bus.bvd1In, 1'b1, "battery one");
    check(bus.bvd2In, 1'b1, "battery two");
    check(bus.readyOut, 1'b1, "ready pin after reset");
    check(bus.wpOut, wpLevel, "protect pin after reset");
    hcmd(1'b0, CF_SP_ATTR, CF_LANE_LO, 11'h202, 16'h0000, rd);
    check(rd[7:0], 8'h00, "status reset value");
    hcmd(1'b0, CF_SP_ATTR, CF_LANE_LO, 11'h000, 16'h0000, rd);
    check(rd[7:0], 8'hff, "card information byte");
    readWord = 16'($random(seed));
    hcmd(1'b0, CF_SP_MEM, CF_LANE_WORD, 11'h000, 16'h0000, rd);
    check(rd, readWord, "word read");
    hcmd(1'b0, CF_SP_MEM, CF_LANE_LO, 11'h000, 16'h0000, rd);
    check(rd[7:0], readWord[7:0], "even byte read");
    fill(CF_SP_MEM, 8, 1'b1);
    hcmd(1'b0, CF_SP_MEM, CF_LANE_LO, 11'h007, 16'h0000, rd);
    check(rd[7:0], 8'h40, "status with FIFO full");
    check(bus.readyOut, 1'b0, "ready pin with FIFO full");
    check(bus.waitN, 1'b0, "wait pin with FIFO full");
    drain();
    $display("test memory done");

    hcmd(1'b1, CF_SP_ATTR, CF_LANE_LO, 11'h200, 16'h0001, rd);
    check(modeNow, CF_IO, "io mode");
    check(bus.bvd2In, 1'b1, "audio idle");
    check(bus.readyOut, 1'b1, "ready pin in io mode");
    check(bus.wpOut, 1'b0, "protect pin in io mode");
    for (int i = 0; i < 5; i++) begin
      en = wv[i][4];
      chg = (chg && !wv[i][5]) || fl[i];
      alert(wv[i], fl[i], {2'b00, chg, en, 4'h0});
    end
    hcmd(1'b0, CF_SP_IO, CF_LANE_LO, 11'h007, 16'h0000, rd);
    check(rd[7:0], 8'h48, "status with FIFO empty");
    readWord = 16'($random(seed));
    hcmd(1'b0, CF_SP_IO, CF_LANE_WORD, 11'h000, 16'h0000, rd);
    check(rd, readWord, "io word read");
    d = 16'($random(seed));
    hcmd(1'b1, CF_SP_IO, CF_LANE_HI, 11'h000, d, rd);
    hcmd(1'b0, CF_SP_IO, CF_LANE_HI, 11'h000, 16'h0000, rd);
    check(rd[15:8], d[7:0], "odd byte read");
    fill(CF_SP_IO, 3, 1'b1);
    drain();
    $display("test io done");

    ideMode = 1'b1;
    hostReset = 1'b1;
    tick(4);
    hostReset = 1'b0;
    tick(8);
    check(modeNow, CF_IDE, "ide mode");
    check(bus.readyOut, 1'b0, "ready pin in ide mode");
    check(bus.wpOut, 1'b1, "protect pin in ide mode");
    for (int i = 0; i < 4; i++) begin
      {diagPass, diskActive} = 2'(i);
      tick(4);
      check(peerDiag, i[1], "pass diagnostic seen");
      check(peerActive, i[0], "slave present seen");
    end
    hcmd(1'b0, CF_SP_IDE, CF_LANE_LO, 11'h7ff, 16'h0000, rd);
    check(rd[7:0], 8'h48, "task register seven");
    fill(CF_SP_IDE, 8, 1'b0);
    drain();
    $display("test ide done");
    testDone();
  end
endmodule
`default_nettype wire
